// File: tb/dac_link_model.sv
// audio link model: sends one sample slot per request, or an empty slot
`timescale 1ns/1ps
`default_nettype none
module dac_link_model import dac_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bench commands
	input wire logic req,
	input wire logic [SMP_W-1:0] reqData,
	input wire logic reqUnder,
	// link side
	output logic sampleTick,
	output dac_smp_t smpIn,
	output logic linkUnderrun
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sampleTick <= 1'b0;
			smpIn <= '0;
			linkUnderrun <= 1'b0;
		end else begin
			sampleTick <= req;
			linkUnderrun <= req & reqUnder;
			smpIn.valid <= req & ~reqUnder;
			// outside a filled slot the data churns so a stale value never matches
			smpIn.data <= (req && !reqUnder) ? reqData : ~smpIn.data;
		end
	end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// testbench: register, regen, event and sample checks for the config bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dac_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic [ADDR_W-1:0] addr = '0;
	logic [31:0] wrData = '0;
	logic wrEn = 0;
	logic rdEn = 0;
	logic [31:0] rdData;
	logic [NPORT-1:0] audioOutEnable = '0;
	logic vblank = 0;
	logic portIsDp = 0;
	logic req = 0;
	logic reqUnder = 0;
	logic [SMP_W-1:0] reqData = '0;
	logic [19:0] dpNow = 20'h06789;
	logic sampleTick, linkUnderrun, unsolResp;
	logic [SMP_W-1:0] lastOut;
	dac_smp_t smpIn, smpOut;
	dac_regen_t regenOut;
	int errors = 0;
	int n_checks = 0;
	int nUnsol = 0;
	int nOut = 0;
	int cycles = 0;

	dac_audio_config DUT (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
		.wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
		.audioOutEnable(audioOutEnable), .vblank(vblank), .portIsDp(portIsDp),
		.dpNCurrent(dpNow), .sampleTick(sampleTick), .smpIn(smpIn),
		.linkUnderrun(linkUnderrun), .smpOut(smpOut), .regenOut(regenOut),
		.unsolResp(unsolResp));
	dac_link_model link (.clk(clk), .rst(rst), .req(req), .reqData(reqData),
		.reqUnder(reqUnder), .sampleTick(sampleTick), .smpIn(smpIn),
		.linkUnderrun(linkUnderrun));

	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (unsolResp === 1'b1) nUnsol++;
		if (smpOut.valid === 1'b1) begin
			nOut++;
			lastOut <= smpOut.data;
		end
		cycles++;
		// whole run needs well under a thousand cycles
		if (cycles == 5000) begin
			errors++;
			conclude();
		end
	end

	task automatic conclude;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic blanks(input int n);
		repeat (n) begin
			@(posedge clk);
			vblank <= 1'b1;
			@(posedge clk);
			vblank <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk);
		rdEn <= 1'b0;
		#1;
		chk({16'h0, rdData}, {16'h0, exp});
	endtask
	task automatic tick(input logic [15:0] d, input logic u);
		@(posedge clk);
		req <= 1'b1;
		reqData <= d;
		reqUnder <= u;
		@(posedge clk);
		req <= 1'b0;
		cyc(5);
	endtask

	task automatic t_reset;
		rd(OFF_CFG, 32'h0070fa60);
		rd(OFF_MISC, MISC_RST);
		rd(OFF_CTS, 32'h0);
		rd(8'h10, 32'h0);
	endtask
	task automatic t_nsel;
		wr(OFF_CFG, 32'he0800007);
		rd(OFF_CFG, 32'h20800000);
		wr(OFF_CFG, 32'h00712340);
		rd(OFF_CFG, 32'h00712340);
		chk({regenOut.active, regenOut.nValue}, {1'b1, 20'h07234});
	endtask
	task automatic t_regen;
		wr(OFF_CFG, 32'h00090000);
		cyc(2);
		chk({regenOut.active, regenOut.pixelRate}, 5'h19);
		wr(OFF_CFG, 32'h000a0000);
		cyc(2);
		chk(regenOut.active, 1'b0);
		wr(OFF_CFG, 32'h00010008);
		cyc(2);
		chk({regenOut.active, regenOut.nValue, regenOut.ctsM}, 0);
		portIsDp <= 1'b1;
		wr(OFF_CFG, 32'h20050000);
		cyc(2);
		chk({regenOut.active, regenOut.isDp, regenOut.pixelRate,
			regenOut.nValue}, {6'h30, 20'h06789});
		wr(OFF_CFG, 32'h30123450);
		cyc(2);
		chk(regenOut.nValue, 20'h01345);
		portIsDp <= 1'b0;
	endtask
	task automatic t_cts;
		wr(OFF_CTS, 32'h00112345);
		rd(OFF_CTS, 32'h00100000);
		wr(OFF_CTS, 32'h00054321);
		rd(OFF_CTS, 32'h00054321);
		wr(OFF_CTS, 32'h00000abc);
		rd(OFF_CTS, 32'h00054321);
		wr(OFF_CTS, 32'hffb00000);
		rd(OFF_CTS, 32'h00300000);
		wr(OFF_CTS, 32'h002abcde);
		rd(OFF_CTS, 32'h002abcde);
		chk(regenOut.ctsM, 20'h54321);
		portIsDp <= 1'b1;
		cyc(2);
		chk(regenOut.ctsM, 20'habcde);
		portIsDp <= 1'b0;
	endtask
	task automatic t_event;
		nUnsol = 0;
		wr(OFF_PORT, 32'h1);
		cyc(4);
		chk(nUnsol, 1);
		audioOutEnable <= 3'b001;
		cyc(4);
		chk(nUnsol, 2);
		blanks(3);
		rd(OFF_PORT, 32'h00030005);
	endtask
	task automatic t_samples;
		wr(OFF_MISC, 32'hffffffff);
		rd(OFF_MISC, 32'h000000f6);
		wr(OFF_MISC, 32'h0);
		nOut = 0;
		tick(16'h1234, 1'b0);
		chk({nOut[15:0], lastOut}, 32'h00011234);
		tick(16'h0, 1'b1);
		chk(nOut, 1);
		wr(OFF_MISC, 32'h4);
		tick(16'h0, 1'b1);
		chk(nOut, 2);
		wr(OFF_MISC, 32'h10);
		tick(16'ha1b2, 1'b0);
		tick(16'hc3d4, 1'b0);
		chk(lastOut, 16'ha1b2);
	endtask
	task automatic t_sequence;
		int n0;
		nUnsol = 0;
		// codec disable while the transcoder still sends blanks
		wr(OFF_MISC, 32'h00000040);
		wr(OFF_CFG, 32'h10000000);
		wr(OFF_PORT, 32'h0);
		blanks(2);
		chk(nUnsol, 1);
		audioOutEnable <= 3'b000;
		// stream stopped: the link only underruns, nothing may come out
		n0 = nOut;
		tick(16'h0, 1'b1);
		chk(nOut, n0);
		// transcoder off: no blanks while rate and CTS change
		wr(OFF_CFG, 32'h10010000);
		wr(OFF_CTS, 32'h00100000);
		wr(OFF_CTS, 32'h00011111);
		rd(OFF_CTS, 32'h00011111);
		// transcoder up and link trained before audio returns
		blanks(1);
		audioOutEnable <= 3'b010;
		blanks(1);
		wr(OFF_PORT, 32'h10);
		wr(OFF_CFG, 32'h0071fa60);
		rd(OFF_CFG, 32'h0071fa60);
		wr(OFF_MISC, 32'h00000044);
		n0 = nOut;
		tick(16'h5a5a, 1'b0);
		chk(nOut, n0 + 1);
		chk(nUnsol, 4);
		rd(OFF_PORT, 32'h00070050);
	endtask

	initial begin
		cyc(12);
		rst <= 1'b0;
		t_reset();
		t_nsel();
		t_regen();
		t_cts();
		t_event();
		t_samples();
		t_sequence();
		conclude();
	end
endmodule
`default_nettype wire

// File: verilog/dac_audio_config.sv
// audio configuration register bank with sample delay and regen control
`timescale 1ns/1ps
`default_nettype none
module dac_audio_config import dac_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [31:0] rdData,
	// display side
	input wire logic [NPORT-1:0] audioOutEnable,
	input wire logic vblank,
	input wire logic portIsDp,
	input wire logic [19:0] dpNCurrent,
	// audio samples
	input wire logic sampleTick,
	input wire dac_smp_t smpIn,
	input wire logic linkUnderrun,
	output dac_smp_t smpOut,
	// regen and codec event
	output dac_regen_t regenOut,
	output logic unsolResp
);
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	dac_cfg_t cfg_reg, cfg_next;
	logic [19:0] hdmiN_reg, hdmiN_next, dpN_reg, dpN_next;
	logic ctsSel_reg, ctsSel_next, ctsPen_reg, ctsPen_next;
	logic [19:0] cts_reg, cts_next, m_reg, m_next;
	logic fill_reg, fill_next, pro_reg, pro_next;
	logic [3:0] dly_reg, dly_next;
	logic [NPORT-1:0] valid_reg, valid_next, prevPd_reg, prevPd_next;
	logic [NPORT-1:0] prevValid_reg, prevValid_next;
	logic [7:0] vbCnt_reg, vbCnt_next;
	logic [31:0] rdData_next;
	logic unsol_next;
	dac_regen_t regen_next;
	logic [SMP_W-1:0] pipe_reg [DLY_DEPTH], pipe_next [DLY_DEPTH];
	dac_smp_t smp_next;
	logic [19:0] nShown, ctsShown;
	logic [31:0] cfgWord, ctsWord, miscWord, portWord;
	logic shiftIn;
	logic [SMP_W-1:0] newSmp;

	// readback views
	always_comb begin
		nShown = cfg_reg.nSel ? dpN_reg : hdmiN_reg;
		ctsShown = ctsSel_reg ? m_reg : cts_reg;
		cfgWord = '0;
		cfgWord[CFG_NSEL] = cfg_reg.nSel;
		cfgWord[CFG_NOVR] = cfg_reg.nOverride;
		cfgWord[CFG_NHI_MSB:CFG_NHI_LSB] = nShown[19:12];
		cfgWord[CFG_RATE_MSB:CFG_RATE_LSB] = cfg_reg.pixelRate;
		cfgWord[CFG_NLO_MSB:CFG_NLO_LSB] = nShown[11:0];
		cfgWord[CFG_REGEN_OFF] = cfg_reg.regenOff;
		ctsWord = '0;
		ctsWord[CTS_SEL] = ctsSel_reg;
		ctsWord[CTS_PEN] = ctsPen_reg;
		ctsWord[19:0] = ctsShown;
		miscWord = '0;
		miscWord[MISC_DLY_MSB:MISC_DLY_LSB] = dly_reg;
		miscWord[MISC_FILL] = fill_reg;
		miscWord[MISC_PRO] = pro_reg;
		portWord = '0;
		for (int p = 0; p < NPORT; p++) begin
			portWord[PORT_STRIDE*p] = valid_reg[p];
			portWord[PORT_STRIDE*p+PORT_PD] = audioOutEnable[p];
		end
		portWord[VB_MSB:VB_LSB] = vbCnt_reg;
	end

	// register writes and reads
	always_comb begin
		cfg_next = cfg_reg;
		hdmiN_next = hdmiN_reg;
		dpN_next = dpN_reg;
		ctsSel_next = ctsSel_reg;
		ctsPen_next = ctsPen_reg;
		cts_next = cts_reg;
		m_next = m_reg;
		fill_next = fill_reg;
		pro_next = pro_reg;
		dly_next = dly_reg;
		valid_next = valid_reg;
		rdData_next = '0;
		if (wrEn && hit(addr, OFF_CFG)) begin
			cfg_next.nSel = wrData[CFG_NSEL];
			cfg_next.nOverride = wrData[CFG_NOVR];
			cfg_next.pixelRate = wrData[CFG_RATE_MSB:CFG_RATE_LSB];
			cfg_next.regenOff = wrData[CFG_REGEN_OFF];
			// N lands in the bank chosen by the select in this write
			if (wrData[CFG_NSEL])
				dpN_next = {wrData[CFG_NHI_MSB:CFG_NHI_LSB],
					wrData[CFG_NLO_MSB:CFG_NLO_LSB]};
			else
				hdmiN_next = {wrData[CFG_NHI_MSB:CFG_NHI_LSB],
					wrData[CFG_NLO_MSB:CFG_NLO_LSB]};
		end
		if (wrEn && hit(addr, OFF_CTS)) begin
			ctsSel_next = wrData[CTS_SEL];
			ctsPen_next = wrData[CTS_PEN];
			// gate uses the enable already held, not the one being written
			if (ctsPen_reg) begin
				if (wrData[CTS_SEL])
					m_next = wrData[19:0];
				else
					cts_next = wrData[19:0];
			end
		end
		if (wrEn && hit(addr, OFF_MISC)) begin
			fill_next = wrData[MISC_FILL];
			pro_next = wrData[MISC_PRO];
			dly_next = wrData[MISC_DLY_MSB:MISC_DLY_LSB];
		end
		if (wrEn && hit(addr, OFF_PORT)) begin
			for (int p = 0; p < NPORT; p++)
				valid_next[p] = wrData[PORT_STRIDE*p];
		end
		if (rdEn) begin
			if (hit(addr, OFF_CFG))
				rdData_next = cfgWord;
			else if (hit(addr, OFF_CTS))
				rdData_next = ctsWord;
			else if (hit(addr, OFF_MISC))
				rdData_next = miscWord;
			else if (hit(addr, OFF_PORT))
				rdData_next = portWord;
		end
	end

	// events: unsolicited response and blank counter
	always_comb begin
		prevValid_next = valid_reg;
		prevPd_next = audioOutEnable;
		unsol_next = (valid_reg != prevValid_reg) ||
			(audioOutEnable != prevPd_reg);
		vbCnt_next = vblank ? vbCnt_reg + 8'h01 : vbCnt_reg;
	end

	// clock regeneration outputs
	always_comb begin
		regen_next.isDp = portIsDp;
		// rate code ignored on DP links
		regen_next.pixelRate = portIsDp ? '0 : cfg_reg.pixelRate;
		regen_next.active = !cfg_reg.regenOff && (portIsDp ||
			cfg_reg.pixelRate <= RATE_MAX);
		if (portIsDp)
			regen_next.nValue = cfg_reg.nOverride ? dpN_reg : dpNCurrent;
		else
			regen_next.nValue = hdmiN_reg;
		regen_next.ctsM = portIsDp ? m_reg : cts_reg;
		if (cfg_reg.regenOff) begin
			regen_next.nValue = '0;
			regen_next.ctsM = '0;
		end
	end

	// sample delay line with underrun fill
	always_comb begin
		shiftIn = sampleTick && (smpIn.valid || (linkUnderrun &&
			fill_reg));
		newSmp = smpIn.valid ? smpIn.data : pipe_reg[0];
		for (int i = 0; i < DLY_DEPTH; i++)
			pipe_next[i] = pipe_reg[i];
		smp_next.valid = shiftIn;
		smp_next.data = smpOut.data;
		if (shiftIn) begin
			pipe_next[0] = newSmp;
			for (int i = 1; i < DLY_DEPTH; i++)
				pipe_next[i] = pipe_reg[i-1];
			smp_next.data = (dly_reg == '0) ? newSmp :
				pipe_reg[dly_reg - 4'h1];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_reg <= '0;
			hdmiN_reg <= HDMI_N_RST;
			dpN_reg <= DP_N_RST;
			ctsSel_reg <= 1'b0;
			ctsPen_reg <= 1'b0;
			cts_reg <= '0;
			m_reg <= '0;
			fill_reg <= MISC_RST[MISC_FILL];
			pro_reg <= MISC_RST[MISC_PRO];
			dly_reg <= MISC_RST[MISC_DLY_MSB:MISC_DLY_LSB];
			valid_reg <= '0;
			prevValid_reg <= '0;
			prevPd_reg <= '0;
			vbCnt_reg <= '0;
			rdData <= '0;
			unsolResp <= 1'b0;
			regenOut <= '0;
			smpOut <= '0;
			for (int i = 0; i < DLY_DEPTH; i++)
				pipe_reg[i] <= '0;
		end else begin
			cfg_reg <= cfg_next;
			hdmiN_reg <= hdmiN_next;
			dpN_reg <= dpN_next;
			ctsSel_reg <= ctsSel_next;
			ctsPen_reg <= ctsPen_next;
			cts_reg <= cts_next;
			m_reg <= m_next;
			fill_reg <= fill_next;
			pro_reg <= pro_next;
			dly_reg <= dly_next;
			valid_reg <= valid_next;
			prevValid_reg <= prevValid_next;
			prevPd_reg <= prevPd_next;
			vbCnt_reg <= vbCnt_next;
			rdData <= rdData_next;
			unsolResp <= unsol_next;
			regenOut <= regen_next;
			smpOut <= smp_next;
			for (int i = 0; i < DLY_DEPTH; i++)
				pipe_reg[i] <= pipe_next[i];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence sCfgRead;
		rdEn && hit(addr, OFF_CFG);
	endsequence
	sequence sCtsRead;
		rdEn && hit(addr, OFF_CTS);
	endsequence
	sequence sMiscRead;
		rdEn && hit(addr, OFF_MISC);
	endsequence
	sequence sCtsWrLocked;
		wrEn && hit(addr, OFF_CTS) && !ctsPen_reg;
	endsequence
	// write edge, then the edge at which the valid bit has moved
	sequence sValidFlip;
		wrEn && hit(addr, OFF_PORT) && wrData[0] != valid_reg[0] ##1 1'b1;
	endsequence

	a_n_readback: assert property (sCfgRead |=>
		rdData[CFG_NLO_MSB:CFG_NLO_LSB] == $past(nShown[11:0]))
		else $error("N readback does not follow the select");
	a_cfg_reserved: assert property (sCfgRead |=>
		rdData[31:30] == 2'b00 && rdData[2:0] == 3'b000)
		else $error("reserved config bits read nonzero");
	a_ctsm_readback: assert property (sCtsRead |=>
		rdData[19:0] == $past(ctsShown))
		else $error("CTS or M readback does not follow the select");
	a_misc_reserved: assert property (sMiscRead |=>
		rdData[31:8] == '0 && !rdData[3] && !rdData[0])
		else $error("reserved misc bits read nonzero");
	a_cts_locked: assert property (sCtsWrLocked |=>
		$stable(cts_reg) && $stable(m_reg))
		else $error("CTS or M changed without enable");
	a_unsol_valid: assert property (sValidFlip |=> unsolResp)
		else $error("no unsolicited response on valid change");
	a_regen_off: assert property (cfg_reg.regenOff |=>
		!regenOut.active && regenOut.ctsM == '0 && regenOut.nValue == '0)
		else $error("regen still active while disabled");
	a_dp_no_rate: assert property (portIsDp |=>
		regenOut.pixelRate == '0)
		else $error("pixel rate applied to DP");
	a_bad_rate: assert property (!portIsDp &&
		cfg_reg.pixelRate > RATE_MAX |=> !regenOut.active)
		else $error("reserved rate code enabled regen");
	a_no_fill: assert property (sampleTick && !smpIn.valid &&
		!fill_reg |=> !smpOut.valid)
		else $error("sample fabricated with fill disabled");
	a_fill_on: assert property (sampleTick && !smpIn.valid &&
		fill_reg && linkUnderrun |=> smpOut.valid)
		else $error("no sample fabricated during underrun");
	a_zero_delay: assert property (sampleTick && smpIn.valid &&
		dly_reg == '0 |=> smpOut.data == $past(smpIn.data))
		else $error("zero delay did not pass sample through");
	a_blank_count: assert property (vblank |=>
		vbCnt_reg == $past(vbCnt_reg) + 8'h01)
		else $error("blank event not counted");
endmodule
`default_nettype wire

// File: verilog/dac_pkg.sv
// package: register map, fields and reset values of the audio config bank
package dac_pkg;
	localparam int ADDR_W = 8;
	localparam int SMP_W = 16;
	localparam int NPORT = 3;
	localparam int DLY_DEPTH = 16;
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_CTS = 8'h04;
	localparam logic [7:0] OFF_MISC = 8'h08;
	localparam logic [7:0] OFF_PORT = 8'h0c;
	// output config fields
	localparam int CFG_NSEL = 29;
	localparam int CFG_NOVR = 28;
	localparam int CFG_NHI_MSB = 27;
	localparam int CFG_NHI_LSB = 20;
	localparam int CFG_RATE_MSB = 19;
	localparam int CFG_RATE_LSB = 16;
	localparam int CFG_NLO_MSB = 15;
	localparam int CFG_NLO_LSB = 4;
	localparam int CFG_REGEN_OFF = 3;
	localparam logic [19:0] HDMI_N_RST = 20'h07fa6;
	localparam logic [19:0] DP_N_RST = 20'h08000;
	localparam logic [3:0] RATE_MAX = 4'h9;
	// cts / m fields
	localparam int CTS_SEL = 21;
	localparam int CTS_PEN = 20;
	// misc fields
	localparam logic [31:0] MISC_RST = 32'h00000044;
	localparam int MISC_FILL = 2;
	localparam int MISC_PRO = 1;
	localparam int MISC_DLY_LSB = 4;
	localparam int MISC_DLY_MSB = 7;
	// port state: valid at 4p, presence at 4p+2, blank count 23:16
	localparam int PORT_STRIDE = 4;
	localparam int PORT_PD = 2;
	localparam int VB_LSB = 16;
	localparam int VB_MSB = 23;

	typedef struct packed {
		logic nSel;
		logic nOverride;
		logic [3:0] pixelRate;
		logic regenOff;
	} dac_cfg_t;

	typedef struct packed {
		logic valid;
		logic [SMP_W-1:0] data;
	} dac_smp_t;

	typedef struct packed {
		logic active;
		logic isDp;
		logic [3:0] pixelRate;
		logic [19:0] nValue;
		logic [19:0] ctsM;
	} dac_regen_t;
endpackage
